/* hardware_monitor_control_tb.sv */
/*
 * Self-checking bench for the monitor control top: register rows,
 * then address strap, pin capture, alarm, reset pulse, test tree.
 * Assumes shortened slot and pulse parameters.
 */
`timescale 1ns/1ps
module hardware_monitor_control_tb;
   typedef struct packed {
      logic [11:0] a;
      logic        w;
      logic [31:0] d;
      logic [31:0] e;
      logic        err;
   } hmc_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  id = 4'h0;
   logic        strap = 1'b0;
   logic        pin_lo = 1'b0;
   logic        v12 = 1'b1;
   logic        send = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        scl;
   logic        sda;
   logic [2:0]  adc_channel;
   logic [6:0]  bus_address;
   logic        bus_address_valid;
   logic        multi_pin_oe;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          errors = 0;
   int          total_checks = 0;
   hmc_row_t    rows [10];
   always #5 pclk = ~pclk;
   hmc_top #(.SHORT_CYC(20), .LONG_CYC(60), .PULSE_CYC(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_id_bit0_input(id[0]), .core_id_bit1_input(id[1]),
      .core_id_bit2_input(id[2]), .core_id_bit3_input(id[3]),
      .twelve_volt_sense_input(v12), .test_tree_strap_input(strap),
      .scl_input(scl), .sda_input(sda), .addr_pin_high(1'b0),
      .addr_pin_low(pin_lo), .adc_value(8'h80),
      .adc_channel(adc_channel), .bus_address(bus_address),
      .bus_address_valid(bus_address_valid), .multi_pin_out(),
      .multi_pin_oe(multi_pin_oe), .irq(irq));
   hmc_smb_master u_smb (.send(send), .scl(scl), .sda(sda));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_ch(input logic [2:0] k);
      int n;
      n = 0;
      while (adc_channel !== k && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(adc_channel), 32'(k), "channel");
   endtask
   function automatic logic nand_oe(input logic [5:0] v);
      logic t;
      t = 1'b1;
      for (int i = 0; i < 6; i++)
         t = ~(t & v[i]);
      return ~t;
   endfunction
   task automatic report_and_stop;
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #300000;
      errors++;
      report_and_stop;
   end
   initial begin
      rows = '{'{12'h000, 1'b0, 32'h0000_0000, 32'h0000_0001, 1'b0},
               '{12'h008, 1'b0, 32'h0000_0000, 32'h0000_00FF, 1'b0},
               '{12'h04C, 1'b0, 32'h0000_0000, 32'h0000_FF00, 1'b0},
               '{12'h004, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{12'h010, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
               '{12'h020, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
               '{12'h020, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
               '{12'h008, 1'b1, 32'h0000_000F, 32'h0000_0000, 1'b0},
               '{12'h008, 1'b0, 32'h0000_0000, 32'h0000_000F, 1'b0},
               '{12'h060, 1'b1, 32'h0000_1234, 32'h0000_0000, 1'b0}};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d, rd, er);
         if (!rows[i].w)
            chk(rd, rows[i].e, "read data");
         chk(32'(er), 32'(rows[i].err), "bus error");
      end
      chk(32'(bus_address_valid), 32'h0000_0000, "early address");
      chk(32'(multi_pin_oe), 32'h0000_0000, "early pin");
      for (int f = 0; f < 2; f++) begin
         send <= 1'b1;
         repeat (120) @(posedge pclk);
         send <= 1'b0;
         pin_lo <= 1'b1;
         apb(hmc_pkg::OFS_PIN_STATE, 1'b0, 32'h0000_0000, rd, er);
         chk(rd, 32'h0000_012E, "address");
      end
      id <= 4'hA;
      repeat (3) @(posedge pclk);
      apb(hmc_pkg::OFS_ID_LOW, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_000A, "id low");
      apb(hmc_pkg::OFS_CONFIG, 1'b1, 32'h0000_0005, rd, er);
      apb(hmc_pkg::OFS_ID_HIGH, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0001, "id high");
      v12 <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(hmc_pkg::OFS_ID_HIGH, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0000, "id high low");
      for (int k = 0; k < 8; k++)
         wait_ch(3'(k));
      apb(12'h048, 1'b1, 32'h0000_1000, rd, er);
      wait_ch(3'h3);
      apb(12'h068, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0080, "value");
      apb(hmc_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0004, "status");
      chk(32'(irq), 32'h0000_0001, "irq");
      chk(32'(multi_pin_oe), 32'h0000_0001, "alert pin");
      apb(hmc_pkg::OFS_MASK, 1'b1, 32'h0000_000B, rd, er);
      @(posedge pclk);
      chk(32'(irq), 32'h0000_0000, "masked irq");
      apb(12'h048, 1'b1, 32'h0000_FF00, rd, er);
      apb(hmc_pkg::OFS_STATUS, 1'b1, 32'h0000_0004, rd, er);
      apb(hmc_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0000, "status clear");
      apb(hmc_pkg::OFS_CONFIG, 1'b1, 32'h0000_000F, rd, er);
      repeat (3) @(posedge pclk);
      chk(32'(multi_pin_oe), 32'h0000_0001, "pulse");
      repeat (12) @(posedge pclk);
      chk(32'(multi_pin_oe), 32'h0000_0000, "pulse end");
      apb(hmc_pkg::OFS_CONFIG, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, 32'h0000_0007, "fire clears");
      strap <= 1'b1;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (60) @(posedge pclk);
      apb(hmc_pkg::OFS_PIN_STATE, 1'b0, 32'h0000_0000, rd, er);
      chk(32'(rd[9]), 32'h0000_0001, "test mode");
      chk(32'(adc_channel), 32'h0000_0000, "no monitoring");
      for (int k = 0; k < 3; k++) begin
         id <= 4'(4'hE >> k);
         repeat (6) @(posedge pclk);
         chk(32'(multi_pin_oe), 32'(nand_oe({sda, scl, id})), "tree");
      end
      report_and_stop;
   end
endmodule

/* hmc_pkg.sv */
/*
 * Constants shared by the hardware monitor control block: register
 * offsets, field positions, reset values and conversion timing.
 * Assumes a 100 MHz register clock and 32-bit APB data.
 */
package hmc_pkg;
   localparam int          CLK_MHZ          = 100;
   // Times in microseconds, as printed
   localparam int          SHORT_CONV_US    = 11600;
   localparam int          LONG_CONV_US     = 185600;
   localparam int          CYCLE_US         = 266800;
   localparam int          RESET_PULSE_US   = 20000;
   localparam int          SHORT_CONV_CYC   = SHORT_CONV_US * CLK_MHZ;
   localparam int          LONG_CONV_CYC    = LONG_CONV_US * CLK_MHZ;
   localparam int          RESET_PULSE_CYC  = RESET_PULSE_US * CLK_MHZ;
   localparam int          NUM_CH           = 8;
   localparam int          NUM_VOLT_CH      = 6;
   localparam int          CH_W             = 3;
   localparam int          CNT_W            = 25;
   // Channel slots within one monitoring cycle
   localparam logic [2:0]  CH_TWELVE        = 3'h0;
   localparam logic [2:0]  CH_SUPPLY        = 3'h5;
   localparam logic [2:0]  CH_INT_TEMP      = 3'h6;
   localparam logic [2:0]  CH_REMOTE_TEMP   = 3'h7;
   // Register byte offsets
   localparam logic [11:0] OFS_CONFIG       = 12'h000;
   localparam logic [11:0] OFS_STATUS       = 12'h004;
   localparam logic [11:0] OFS_MASK         = 12'h008;
   localparam logic [11:0] OFS_ID_LOW       = 12'h00C;
   localparam logic [11:0] OFS_ID_HIGH      = 12'h010;
   localparam logic [11:0] OFS_PIN_STATE    = 12'h014;
   localparam logic [11:0] OFS_LIMIT_BASE   = 12'h040;
   localparam logic [11:0] OFS_VALUE_BASE   = 12'h060;
   // Configuration fields
   localparam int          CFG_START        = 0;
   localparam int          CFG_PIN_RESET    = 1;
   localparam int          CFG_ID_MODE      = 2;
   localparam int          CFG_FIRE_RESET   = 3;
   localparam logic [3:0]  CONFIG_RESET     = 4'h1;
   localparam logic [7:0]  MASK_RESET       = 8'hFF;
   localparam logic [15:0] LIMIT_RESET      = 16'hFF00;
   // Fixed upper part of the seven-bit serial address
   localparam logic [4:0]  ADDR_UPPER       = 5'b01011;
   localparam logic [1:0]  ADDR_GND         = 2'b00;
   localparam logic [1:0]  ADDR_OPEN        = 2'b10;
   localparam logic [1:0]  ADDR_VCC         = 2'b01;
endpackage

/* hmc_seq_if.sv */
/*
 * Carries the conversion slot handshake between the control top and
 * its sequencer. Both ends share the same clock.
 */
`timescale 1ns/1ps
interface hmc_seq_if;
   logic       run;
   logic [2:0] channel;
   logic       conv_done;
   modport seq  (input run, output channel, output conv_done);
   modport ctrl (output run, input channel, input conv_done);
endinterface

/* hmc_sequencer.sv */
/*
 * Monitoring sequencer: steps through eight conversion slots, six
 * voltages then internal and remote temperature, and pulses conv_done
 * at the end of each slot. Assumes run is synchronous to clk.
 */
`timescale 1ns/1ps
module hmc_sequencer #(
   parameter int SHORT_CYC = hmc_pkg::SHORT_CONV_CYC,
   parameter int LONG_CYC  = hmc_pkg::LONG_CONV_CYC
) (
   input wire logic   pclk,
   input wire logic   presetn,
   hmc_seq_if.seq     sq
);
   typedef enum logic {HMC_IDLE, HMC_CONVERT} hmc_seq_state_t;

   hmc_seq_state_t                  state;
   hmc_seq_state_t                  next_state;
   logic [hmc_pkg::CNT_W-1:0]       count;
   logic [hmc_pkg::CNT_W-1:0]       next_count;
   logic [2:0]                      channel;
   logic [2:0]                      next_channel;

   function automatic logic [hmc_pkg::CNT_W-1:0] slot_len(
      input logic [2:0] ch);
      // Remote diode needs the long slot; all others the short one
      if (ch == hmc_pkg::CH_REMOTE_TEMP) begin
         slot_len = hmc_pkg::CNT_W'(LONG_CYC - 1);
      end else begin
         slot_len = hmc_pkg::CNT_W'(SHORT_CYC - 1);
      end
   endfunction

   always_comb begin
      next_state   = state;
      next_count   = count;
      next_channel = channel;
      case (state)
         HMC_IDLE: begin
            next_channel = 3'h0;
            next_count   = slot_len(3'h0);
            if (sq.run) begin
               next_state = HMC_CONVERT;
            end
         end
         HMC_CONVERT: begin
            if (!sq.run) begin
               next_state = HMC_IDLE;
            end else if (count == '0) begin
               // Eight slots wrap so the cycle repeats
               next_channel = channel + 3'h1;
               next_count   = slot_len(channel + 3'h1);
            end else begin
               next_count = count - 1'b1;
            end
         end
         default: next_state = HMC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= HMC_IDLE;
         count   <= '0;
         channel <= 3'h0;
      end else begin
         state   <= next_state;
         count   <= next_count;
         channel <= next_channel;
      end
   end

   assign sq.channel   = channel;
   // Combinational, so the result is filed under the slot's own channel
   assign sq.conv_done = (state == HMC_CONVERT) && sq.run && (count == '0);
endmodule

/* hmc_smb_master.sv */
/*
 * Behavioural serial bus master: each rise of send gives one frame,
 * start, eight address bits, released acknowledge, stop.
 * Assumes pull-ups hold both lines high between frames.
 */
`timescale 1ns/1ps
module hmc_smb_master #(
   parameter logic [7:0] FRAME = 8'h5C
) (
   input  wire logic send,
   output logic      scl,
   output logic      sda
);
   // One process drives both lines; clock runs only inside a frame
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      forever begin
         @(posedge send);
         sda = 1'b0;
         #40;
         for (int i = 0; i < 9; i++) begin
            scl = 1'b0;
            #20;
            sda = (i < 8) ? FRAME[7 - i] : 1'b1;
            #20;
            scl = 1'b1;
            #40;
         end
         scl = 1'b0;
         #20;
         sda = 1'b0;
         #20;
         scl = 1'b1;
         #20;
         sda = 1'b1;
      end
   end
endmodule

/* hmc_top.sv */
/*
 * Hardware monitor control: APB register file, monitoring sequencer,
 * limit checks with sticky status and interrupt, identification pin
 * capture, power-up straps and the multi-function pin. Assumes the
 * analog front end presents adc_value for adc_channel at conv end,
 * in the pclk domain; all pins are asynchronous to pclk.
 */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module hmc_top #(
   parameter int SHORT_CYC = hmc_pkg::SHORT_CONV_CYC,
   parameter int LONG_CYC  = hmc_pkg::LONG_CONV_CYC,
   parameter int PULSE_CYC = hmc_pkg::RESET_PULSE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        core_id_bit0_input,
   input  wire logic        core_id_bit1_input,
   input  wire logic        core_id_bit2_input,
   input  wire logic        core_id_bit3_input,
   input  wire logic        twelve_volt_sense_input,
   input  wire logic        test_tree_strap_input,
   input  wire logic        scl_input,
   input  wire logic        sda_input,
   input  wire logic        addr_pin_high,
   input  wire logic        addr_pin_low,
   input  wire logic [7:0]  adc_value,
   output logic      [2:0]  adc_channel,
   output logic      [6:0]  bus_address,
   output logic             bus_address_valid,
   output logic             multi_pin_out,
   output logic             multi_pin_oe,
   output logic             irq
);
   localparam int NCH = hmc_pkg::NUM_CH;
   localparam int NS  = 10;
   // Serial lines idle high, so reset must not fake an edge on them
   localparam logic [NS-1:0] SYNC_IDLE = 10'h0C0;
   typedef enum logic [1:0] {HMC_WAIT_STRAP, HMC_TEST, HMC_WAIT_ADDR,
                             HMC_NORMAL} hmc_pin_state_t;

   hmc_seq_if sq ();

   // Pin synchronisers: first stage read only by the second
   logic [NS-1:0]  sync1;
   logic [NS-1:0]  sync2;
   logic [NS-1:0]  pin_raw;
   logic           scl_prev;
   logic           sda_prev;

   assign pin_raw = {addr_pin_low, addr_pin_high, sda_input, scl_input,
                     test_tree_strap_input, twelve_volt_sense_input,
                     core_id_bit3_input, core_id_bit2_input,
                     core_id_bit1_input, core_id_bit0_input};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1    <= SYNC_IDLE;
         sync2    <= SYNC_IDLE;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         sync1    <= pin_raw;
         sync2    <= sync1;
         scl_prev <= sync2[6];
         sda_prev <= sync2[7];
      end
   end

   // Registers
   logic [3:0]     config_q;
   logic [3:0]     next_config;
   logic [7:0]     status;
   logic [7:0]     next_status;
   logic [7:0]     mask;
   logic [7:0]     next_mask;
   logic [15:0]    limit     [NCH];
   logic [15:0]    next_limit[NCH];
   logic [7:0]     value     [NCH];
   logic [7:0]     next_value[NCH];
   logic [3:0]     id_low;
   logic [3:0]     next_id_low;
   logic           id_high;
   logic           next_id_high;
   logic           wr_en;
   logic           rd_hit;
   logic [7:0]     out_of_limit;

   function automatic logic reg_is(input logic [11:0] a,
                                   input logic [11:0] ofs);
      reg_is = (a == ofs);
   endfunction

   // Limit or value slot index, or NCH when outside the window
   function automatic int slot_of(input logic [11:0] a,
                                  input logic [11:0] base);
      slot_of = NCH;
      if (a >= base && a < base + 12'(4 * NCH) && a[1:0] == 2'b00) begin
         slot_of = int'((a - base) >> 2);
      end
   endfunction

   assign wr_en = psel && penable && pwrite;

   always_comb begin
      out_of_limit = 8'h00;
      if (sq.conv_done) begin
         // Twelve-volt channel has no meaning in identification mode
         if (!(sq.channel == hmc_pkg::CH_TWELVE &&
               config_q[hmc_pkg::CFG_ID_MODE]) &&
             (adc_value > limit[sq.channel][15:8] ||
              adc_value < limit[sq.channel][7:0])) begin
            out_of_limit[sq.channel] = 1'b1;
         end
      end
   end

   always_comb begin
      next_config = config_q;
      next_config[hmc_pkg::CFG_FIRE_RESET] = 1'b0;
      next_mask   = mask;
      next_status = status;
      next_limit  = limit;
      next_value  = value;
      if (sq.conv_done) begin
         next_value[sq.channel] = adc_value;
      end
      if (wr_en) begin
         if (reg_is(paddr, hmc_pkg::OFS_CONFIG)) begin
            next_config = pwdata[3:0];
         end
         if (reg_is(paddr, hmc_pkg::OFS_MASK)) begin
            next_mask = pwdata[7:0];
         end
         if (reg_is(paddr, hmc_pkg::OFS_STATUS)) begin
            next_status = status & ~pwdata[7:0];
         end
         if (slot_of(paddr, hmc_pkg::OFS_LIMIT_BASE) < NCH) begin
            next_limit[slot_of(paddr, hmc_pkg::OFS_LIMIT_BASE)] =
               pwdata[15:0];
         end
      end
      // A new event wins over a clear in the same cycle
      next_status  = next_status | out_of_limit;
      next_id_low  = sync2[3:0];
      next_id_high = config_q[hmc_pkg::CFG_ID_MODE] & sync2[4];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_q <= hmc_pkg::CONFIG_RESET;
         status   <= 8'h00;
         mask     <= hmc_pkg::MASK_RESET;
         id_low   <= 4'h0;
         id_high  <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            limit[i] <= hmc_pkg::LIMIT_RESET;
            value[i] <= 8'h00;
         end
      end else begin
         config_q <= next_config;
         status   <= next_status;
         mask     <= next_mask;
         id_low   <= next_id_low;
         id_high  <= next_id_high;
         limit    <= next_limit;
         value    <= next_value;
      end
   end

   // Straps, address capture and multi-function pin
   hmc_pin_state_t pin_state;
   hmc_pin_state_t next_pin_state;
   logic [1:0]     settle;
   logic [1:0]     next_settle;
   logic [1:0]     addr_low;
   logic [1:0]     next_addr_low;
   logic [31:0]    pulse_cnt;
   logic [31:0]    next_pulse_cnt;
   logic           test_tree_result_output;
   logic           bus_activity;
   logic [1:0]     strap_code;

   // Chain of two-input NAND gates across the four ID inputs and both serial lines
   function automatic logic nand_chain(input logic [5:0] ins);
      logic acc;
      acc = 1'b1;
      for (int i = 0; i < 6; i++) begin
         acc = ~(acc & ins[i]);
      end
      nand_chain = acc;
   endfunction

   assign test_tree_result_output = nand_chain({sync2[7:6], sync2[3:0]});
   assign bus_activity = (sync2[6] != scl_prev) || (sync2[7] != sda_prev);
   assign strap_code   = sync2[9] ? hmc_pkg::ADDR_GND :
                         sync2[8] ? hmc_pkg::ADDR_VCC : hmc_pkg::ADDR_OPEN;

   always_comb begin
      next_pin_state = pin_state;
      next_settle    = settle;
      next_addr_low  = addr_low;
      next_pulse_cnt = pulse_cnt;
      case (pin_state)
         HMC_WAIT_STRAP: begin
            // Wait until the synchronisers hold real pin levels
            next_settle = settle + 2'h1;
            if (settle == 2'h3) begin
               next_pin_state = sync2[5] ? HMC_TEST
                                         : HMC_WAIT_ADDR;
            end
         end
         HMC_TEST: next_pin_state = HMC_TEST;
         HMC_WAIT_ADDR: begin
            if (bus_activity) begin
               next_addr_low  = strap_code;
               next_pin_state = HMC_NORMAL;
            end
         end
         HMC_NORMAL: begin
            if (pulse_cnt != 32'h0000_0000) begin
               next_pulse_cnt = pulse_cnt - 32'h0000_0001;
            end
            if (config_q[hmc_pkg::CFG_FIRE_RESET] &&
                config_q[hmc_pkg::CFG_PIN_RESET]) begin
               next_pulse_cnt = 32'(PULSE_CYC);
            end
         end
         default: next_pin_state = HMC_WAIT_STRAP;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_state <= HMC_WAIT_STRAP;
         settle    <= 2'h0;
         addr_low  <= hmc_pkg::ADDR_GND;
         pulse_cnt <= 32'h0000_0000;
      end else begin
         pin_state <= next_pin_state;
         settle    <= next_settle;
         addr_low  <= next_addr_low;
         pulse_cnt <= next_pulse_cnt;
      end
   end

   // Open drain: the pin is only ever pulled low
   always_comb begin
      multi_pin_out = 1'b0;
      multi_pin_oe  = 1'b0;
      case (pin_state)
         HMC_TEST: multi_pin_oe = ~test_tree_result_output;
         HMC_NORMAL: begin
            if (config_q[hmc_pkg::CFG_PIN_RESET]) begin
               multi_pin_oe = (pulse_cnt != 32'h0000_0000);
            end else begin
               multi_pin_oe = irq;
            end
         end
         default: multi_pin_oe = 1'b0;
      endcase
   end

   assign irq               = |(status & mask);
   assign bus_address       = {hmc_pkg::ADDR_UPPER, addr_low};
   assign bus_address_valid = (pin_state == HMC_NORMAL);
   assign sq.run            = config_q[hmc_pkg::CFG_START] &&
                              (pin_state != HMC_TEST) &&
                              (pin_state != HMC_WAIT_STRAP);
   assign adc_channel       = sq.channel;

   hmc_sequencer #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .sq      (sq)
   );

   // APB read side; zero wait states, unmapped offsets flag an error
   always_comb begin
      prdata = 32'h0000_0000;
      rd_hit = 1'b1;
      if (reg_is(paddr, hmc_pkg::OFS_CONFIG)) begin
         prdata = {28'h000_0000, config_q};
      end else if (reg_is(paddr, hmc_pkg::OFS_STATUS)) begin
         prdata = {24'h00_0000, status};
      end else if (reg_is(paddr, hmc_pkg::OFS_MASK)) begin
         prdata = {24'h00_0000, mask};
      end else if (reg_is(paddr, hmc_pkg::OFS_ID_LOW)) begin
         prdata = {28'h000_0000, id_low};
      end else if (reg_is(paddr, hmc_pkg::OFS_ID_HIGH)) begin
         prdata = {31'h0000_0000, id_high};
      end else if (reg_is(paddr, hmc_pkg::OFS_PIN_STATE)) begin
         prdata = {22'h00_0000, (pin_state == HMC_TEST),
                   bus_address_valid, 1'b0, bus_address};
      end else if (slot_of(paddr, hmc_pkg::OFS_LIMIT_BASE) < NCH) begin
         prdata = {16'h0000, limit[slot_of(paddr, hmc_pkg::OFS_LIMIT_BASE)]};
      end else if (slot_of(paddr, hmc_pkg::OFS_VALUE_BASE) < NCH) begin
         prdata = {24'h00_0000,
                   value[slot_of(paddr, hmc_pkg::OFS_VALUE_BASE)]};
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rd_hit;
endmodule

/* hmc_top_chk.sv */
/*
 * Concurrent checks on the monitor control top: serial address,
 * slot order and length, reset pulse and register bus answer.
 * Assumes the ports and slot parameters of hmc_top; bound below.
 */
`timescale 1ns/1ps
module hmc_top_chk #(
   parameter int SHORT_CYC = 20,
   parameter int LONG_CYC  = 60
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        addr_pin_high,
   input wire logic        addr_pin_low,
   input wire logic [2:0]  adc_channel,
   input wire logic [6:0]  bus_address,
   input wire logic        bus_address_valid,
   input wire logic        multi_pin_oe
);
   logic [2:0]  prev_ch;
   logic [31:0] run;
   logic [31:0] next_run;
   logic [2:0]  next_prev_ch;
   // Cycles spent in the current slot; restarts on every step
   always_comb begin
      next_prev_ch = adc_channel;
      next_run = (adc_channel != prev_ch) ? 32'h0000_0001
                                          : run + 32'h0000_0001;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ch <= 3'h0;
         run     <= 32'h0000_0000;
      end else begin
         prev_ch <= next_prev_ch;
         run     <= next_run;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_fire;
      psel && penable && pready && pwrite && paddr == 12'h000
         && pwdata[3] && pwdata[1] && bus_address_valid;
   endsequence
   sequence s_low;
      multi_pin_oe [*8];
   endsequence
   property p_pulse;
      s_fire |-> ##[1:3] s_low;
   endproperty
   property p_upper;
      bus_address_valid |-> bus_address[6:2] == hmc_pkg::ADDR_UPPER;
   endproperty
   property p_hold;
      $past(bus_address_valid) |-> bus_address_valid && $stable(bus_address);
   endproperty
   property p_strap;
      $rose(bus_address_valid) |-> bus_address[1:0] == (addr_pin_low ?
         hmc_pkg::ADDR_GND : addr_pin_high ? hmc_pkg::ADDR_VCC
         : hmc_pkg::ADDR_OPEN);
   endproperty
   property p_order;
      $changed(adc_channel) |->
         adc_channel == $past(adc_channel) + 3'h1 || adc_channel == 3'h0;
   endproperty
   property p_short;
      $changed(adc_channel) && $past(adc_channel) != 3'h0
         && $past(adc_channel) != 3'h7 && adc_channel != 3'h0
         |-> run == SHORT_CYC;
   endproperty
   property p_long;
      $changed(adc_channel) && $past(adc_channel) == 3'h7 |-> run == LONG_CYC;
   endproperty
   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("reset pulse too short");
   a_upper: assert property (p_upper)
      else $error("address upper bits wrong");
   a_hold: assert property (p_hold)
      else $error("address changed after capture");
   a_strap: assert property (p_strap)
      else $error("address strap decoded wrongly");
   a_order: assert property (p_order)
      else $error("channel order broken");
   a_short: assert property (p_short)
      else $error("short slot length wrong");
   a_long: assert property (p_long)
      else $error("remote slot length wrong");
   a_ready: assert property (p_ready)
      else $error("bus access not answered");
endmodule

bind hmc_top hmc_top_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .addr_pin_high(addr_pin_high), .addr_pin_low(addr_pin_low),
   .adc_channel(adc_channel), .bus_address(bus_address),
   .bus_address_valid(bus_address_valid), .multi_pin_oe(multi_pin_oe));
